/* sat_pkg.sv */
// Shared constants and types for the segment address translator
package sat_pkg;
  localparam int SAT_SEG_W = 7;
  localparam int SAT_OFS_W = 16;
  localparam int SAT_BASE_W = 16;
  localparam int SAT_PHYS_W = 24;
  localparam int SAT_BYTE_W = 8;
  localparam int SAT_NSEG = 128;
  localparam int SAT_ATTR_W = 8;
  // Attribute bit positions (set bit prohibits; REF and CHG record use instead)
  localparam int SAT_ATTR_RD = 0;
  localparam int SAT_ATTR_SYS = 1;
  localparam int SAT_ATTR_CPUI = 2;
  localparam int SAT_ATTR_EXC = 3;
  localparam int SAT_ATTR_REF = 7;
  localparam int SAT_ATTR_CHG = 6;
  // Command register select on the address/data low bits
  localparam logic [1:0] SAT_CMD_BASE = 2'h0;
  localparam logic [1:0] SAT_CMD_LIMIT = 2'h1;
  localparam logic [1:0] SAT_CMD_ATTR = 2'h2;
  localparam logic [7:0] SAT_LIMIT_RST = 8'hFF;
  localparam logic [7:0] SAT_ATTR_RST = 8'h00;
  localparam logic [15:0] SAT_BASE_RST = 16'h0000;

  // Bus status codes
  typedef enum logic [3:0] {
    SAT_ST_INTERNAL = 4'h0,
    SAT_ST_REFRESH = 4'h1,
    SAT_ST_IO = 4'h2,
    SAT_ST_SPECIAL_IO = 4'h3,
    SAT_ST_OPFETCH = 4'h4,
    SAT_ST_DATA = 4'h5,
    SAT_ST_STACK = 4'h6,
    SAT_ST_FETCH_CONT = 4'h7
  } sat_status_t;

  typedef enum logic [2:0] {
    SAT_MODE_XLATE = 3'h1,
    SAT_MODE_CMD = 3'h2,
    SAT_MODE_QUIET = 3'h4
  } sat_mode_t;
endpackage

/* sat_if.sv */
// Processor-side bus joining the processor end and the translator end
`timescale 1ns/1ns
interface sat_if;
  import sat_pkg::*;
  logic first_cycle;
  logic cycle_valid;
  logic dma_cycle;
  logic instr_end;
  sat_status_t status;
  logic system_mode;
  logic write_n;
  logic [SAT_SEG_W-1:0] seg_num;
  logic [SAT_OFS_W-1:0] ad;
  logic [SAT_OFS_W-1:0] ad_rd;
  logic [SAT_BASE_W-1:0] addr_out;
  logic addr_oe_n;
  logic seg_trap;
  logic suppress;
  logic trap_ack;

  modport dev (
    input first_cycle, cycle_valid, dma_cycle, instr_end, status, system_mode, write_n,
    seg_num, ad, trap_ack,
    output ad_rd, addr_out, addr_oe_n, seg_trap, suppress
  );
  modport cpu (
    output first_cycle, cycle_valid, dma_cycle, instr_end, status, system_mode, write_n,
    seg_num, ad, trap_ack,
    input ad_rd, addr_out, addr_oe_n, seg_trap, suppress
  );
endinterface

/* sat_cpu_end.sv */
// Processor end: presents bus cycles and acknowledges segment traps
`timescale 1ns/1ns
module sat_cpu_end
  import sat_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Link
  sat_if.cpu bus,
  // User request
  input wire logic req_valid,
  input wire logic req_first,
  input wire logic req_last,
  input wire logic req_dma,
  input wire sat_status_t req_status,
  input wire logic req_system,
  input wire logic req_write,
  input wire logic [SAT_SEG_W-1:0] req_seg,
  input wire logic [SAT_OFS_W-1:0] req_ofs,
  // User answer
  output logic [SAT_PHYS_W-1:0] phys_addr,
  output logic phys_valid,
  output logic trap_seen,
  output logic suppress_seen,
  output logic [SAT_OFS_W-1:0] cmd_data
);
  import sat_pkg::*;
  logic trap_ack_q, trap_ack_d;
  // Low byte delayed to pair with the registered high part
  logic [SAT_BYTE_W-1:0] ofs_lo_q;

  // Cycle type, mode and read/write published every cycle
  assign bus.cycle_valid = req_valid;
  assign bus.status = req_status;
  assign bus.system_mode = req_system;
  assign bus.write_n = ~req_write;
  assign bus.first_cycle = req_first;
  assign bus.instr_end = req_last;
  assign bus.dma_cycle = req_dma;
  assign bus.seg_num = req_seg;
  assign bus.ad = req_ofs;
  assign bus.trap_ack = trap_ack_q;

  // Acknowledge one cycle after seeing a held trap
  always_comb
  begin
    trap_ack_d = bus.seg_trap & ~trap_ack_q;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      trap_ack_q <= 1'b0;
      phys_addr <= '0;
      phys_valid <= 1'b0;
      trap_seen <= 1'b0;
      suppress_seen <= 1'b0;
      cmd_data <= '0;
      ofs_lo_q <= '0;
    end
    else
    begin
      trap_ack_q <= trap_ack_d;
      ofs_lo_q <= req_ofs[SAT_BYTE_W-1:0];
      phys_addr <= {bus.addr_out, ofs_lo_q};
      phys_valid <= ~bus.addr_oe_n;
      trap_seen <= bus.seg_trap;
      suppress_seen <= bus.suppress;
      cmd_data <= bus.ad_rd;
    end
  end
endmodule

/* sat_mmu.sv */
// Translator end: segment table, protection checks, trap and suppress
`timescale 1ns/1ns
module sat_mmu
  import sat_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Link
  sat_if.dev bus,
  // Status
  output sat_mode_t mode,
  output logic violation
);
  import sat_pkg::*;

  // Descriptor table, one entry per segment
  logic [SAT_BASE_W-1:0] base_q [SAT_NSEG];
  logic [SAT_BYTE_W-1:0] limit_q [SAT_NSEG];
  logic [SAT_ATTR_W-1:0] attr_q [SAT_NSEG];

  sat_mode_t mode_q, mode_d;
  logic trap_q, trap_d;
  logic supp_q, supp_d;
  logic [SAT_BASE_W-1:0] addr_q, addr_d;
  logic oe_n_q, oe_n_d;
  logic [SAT_OFS_W-1:0] rd_q, rd_d;
  logic [SAT_SEG_W-1:0] cmd_seg_q, cmd_seg_d;
  logic [1:0] cmd_fld_q, cmd_fld_d;
  logic arm_q, arm_d;

  logic [SAT_BASE_W-1:0] sel_base;
  logic [SAT_BYTE_W-1:0] sel_limit;
  logic [SAT_ATTR_W-1:0] sel_attr;
  logic mem_cycle, is_fetch, is_write, viol;
  sat_mode_t cur_mode;

  assign sel_base = base_q[bus.seg_num];
  assign sel_limit = limit_q[bus.seg_num];
  assign sel_attr = attr_q[bus.seg_num];

  always_comb
  begin
    mem_cycle = bus.status == SAT_ST_OPFETCH || bus.status == SAT_ST_DATA ||
                bus.status == SAT_ST_STACK || bus.status == SAT_ST_FETCH_CONT;
    is_fetch = bus.status == SAT_ST_OPFETCH || bus.status == SAT_ST_FETCH_CONT;
    is_write = ~bus.write_n;
    // Limit counts 256-byte blocks; block index is offset high byte
    viol = bus.ad[SAT_OFS_W-1:SAT_BYTE_W] > sel_limit;
    if (sel_attr[SAT_ATTR_SYS] && !bus.system_mode)
      viol = 1'b1;
    if (sel_attr[SAT_ATTR_RD] && is_write)
      viol = 1'b1;
    if (sel_attr[SAT_ATTR_EXC] && !is_fetch)
      viol = 1'b1;
    if (sel_attr[SAT_ATTR_CPUI] && !bus.dma_cycle)
      viol = 1'b1;
    viol = viol & bus.cycle_valid & mem_cycle;
  end

  // Mode chosen from status on the first cycle only
  always_comb
  begin
    mode_d = mode_q;
    if (bus.cycle_valid && bus.first_cycle)
    begin
      case (bus.status)
        SAT_ST_SPECIAL_IO: mode_d = SAT_MODE_CMD;
        SAT_ST_IO, SAT_ST_REFRESH, SAT_ST_INTERNAL: mode_d = SAT_MODE_QUIET;
        default: mode_d = SAT_MODE_XLATE;
      endcase
    end
    cur_mode = mode_d;
  end

  always_comb
  begin
    trap_d = trap_q;
    supp_d = 1'b0;
    addr_d = addr_q;
    oe_n_d = 1'b1;
    rd_d = rd_q;
    cmd_seg_d = cmd_seg_q;
    cmd_fld_d = cmd_fld_q;
    case (cur_mode)
      SAT_MODE_XLATE:
      begin
        if (bus.cycle_valid && mem_cycle)
        begin
          addr_d = sel_base + {{SAT_BYTE_W{1'b0}}, bus.ad[SAT_OFS_W-1:SAT_BYTE_W]};
          oe_n_d = 1'b0;
        end
      end
      SAT_MODE_CMD:
      begin
        // First word picks segment and field, so a full base word can follow
        if (bus.cycle_valid && bus.first_cycle)
        begin
          cmd_seg_d = bus.seg_num;
          cmd_fld_d = bus.ad[1:0];
        end
        case (cmd_fld_q)
          SAT_CMD_BASE: rd_d = base_q[cmd_seg_q];
          SAT_CMD_LIMIT: rd_d = {{SAT_BYTE_W{1'b0}}, limit_q[cmd_seg_q]};
          default: rd_d = {{SAT_BYTE_W{1'b0}}, attr_q[cmd_seg_q]};
        endcase
      end
      SAT_MODE_QUIET: oe_n_d = 1'b1;
      default: oe_n_d = 1'b1;
    endcase
    // Acknowledge clears, but a fresh violation wins
    if (bus.trap_ack)
      trap_d = 1'b0;
    if (viol)
      trap_d = 1'b1;
    // Armed for the rest of the instruction; DMA cycles only on their own fault
    arm_d = (viol | arm_q) & ~bus.instr_end;
    supp_d = viol | (arm_q & ~bus.dma_cycle);
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mode_q <= SAT_MODE_XLATE;
      trap_q <= 1'b0;
      supp_q <= 1'b0;
      addr_q <= '0;
      oe_n_q <= 1'b1;
      rd_q <= '0;
      cmd_seg_q <= '0;
      cmd_fld_q <= '0;
      arm_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      trap_q <= trap_d;
      supp_q <= supp_d;
      arm_q <= arm_d;
      cmd_fld_q <= cmd_fld_d;
      addr_q <= addr_d;
      oe_n_q <= oe_n_d;
      rd_q <= rd_d;
      cmd_seg_q <= cmd_seg_d;
    end
  end

  // Descriptor storage; history bits set by hardware win over command writes
  genvar g;
  generate
    for (g = 0; g < SAT_NSEG; g++)
    begin : g_seg
      logic hit, wr;
      assign hit = bus.cycle_valid && mem_cycle && cur_mode == SAT_MODE_XLATE &&
                   bus.seg_num == SAT_SEG_W'(g) && !viol;
      assign wr = cur_mode == SAT_MODE_CMD && bus.cycle_valid && !bus.first_cycle &&
                  !bus.write_n && cmd_seg_q == SAT_SEG_W'(g);
      always_ff @(posedge mclk)
      begin
        if (sys_rst)
        begin
          base_q[g] <= SAT_BASE_RST;
          limit_q[g] <= SAT_LIMIT_RST;
          attr_q[g] <= SAT_ATTR_RST;
        end
        else
        begin
          if (wr && cmd_fld_q == SAT_CMD_BASE)
            base_q[g] <= bus.ad;
          if (wr && cmd_fld_q == SAT_CMD_LIMIT)
            limit_q[g] <= bus.ad[SAT_OFS_W-1:SAT_BYTE_W];
          if (wr && cmd_fld_q == SAT_CMD_ATTR)
            attr_q[g] <= bus.ad[SAT_OFS_W-1:SAT_BYTE_W];
          if (hit)
          begin
            attr_q[g][SAT_ATTR_REF] <= 1'b1;
            if (!bus.write_n)
              attr_q[g][SAT_ATTR_CHG] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Outputs valid in the cycle after the address is presented
  assign bus.addr_out = addr_q;
  assign bus.addr_oe_n = oe_n_q;
  assign bus.seg_trap = trap_q;
  assign bus.suppress = supp_q;
  assign bus.ad_rd = rd_q;
  assign mode = mode_q;
  assign violation = supp_q;
endmodule

/* sat_chk.sv */
// Assertions on the processor-side bus
`timescale 1ns/1ns
module sat_chk
  import sat_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Bus
  input wire logic first_cycle,
  input wire logic cycle_valid,
  input wire logic dma_cycle,
  input wire logic instr_end,
  input wire sat_pkg::sat_status_t status,
  input wire logic trap_ack,
  input wire logic addr_oe_n,
  input wire logic seg_trap,
  input wire logic suppress
);
  import sat_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic start = cycle_valid && first_cycle;
  a_rst_idle: assert property (disable iff (1'b0) sys_rst |=> addr_oe_n && !seg_trap && !suppress)
    else $error("outputs busy after reset");
  a_quiet_float: assert property (start && status inside {SAT_ST_IO, SAT_ST_REFRESH} |=> addr_oe_n)
    else $error("address driven in quiet cycle");
  a_mem_drive: assert property (start && status inside {SAT_ST_OPFETCH, SAT_ST_DATA, SAT_ST_STACK} |=> !addr_oe_n)
    else $error("address not driven");
  a_trap_hold: assert property ($fell(seg_trap) |-> $past(trap_ack))
    else $error("trap dropped without ack");
  a_trap_cause: assert property ($rose(seg_trap) |-> $past(cycle_valid))
    else $error("trap without bus cycle");
  a_supp_pair: assert property ($rose(suppress) && !$past(dma_cycle, 2) |-> seg_trap)
    else $error("suppress without trap");
  a_supp_hold: assert property ($fell(suppress) |-> $past(instr_end, 2) || $past(dma_cycle))
    else $error("suppress dropped early");
  a_ack_clear: assert property (trap_ack && seg_trap && !cycle_valid |=> !seg_trap)
    else $error("trap kept after ack");
  cover property ($rose(seg_trap));
  cover property ($fell(suppress));
  cover property (start && status == SAT_ST_SPECIAL_IO);
endmodule

/* segment_address_translator_test.sv */
// Testbench joining the processor end to the translator end
`timescale 1ns/1ns
module segment_address_translator_test;
  import sat_pkg::*;
  typedef struct {logic [6:0] seg; logic [15:0] base; logic [7:0] lim, attr; logic sy, wr;
    sat_status_t st; logic [15:0] ofs; logic [23:0] phys; logic trap;} sat_row_t;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0, req_first = 1'b0, req_last = 1'b0, req_system = 1'b0, req_write = 1'b0;
  sat_status_t req_status = SAT_ST_INTERNAL;
  logic [6:0] req_seg = 7'h00;
  logic [15:0] req_ofs = 16'h0000, cmd_data;
  logic [23:0] phys_addr;
  logic trap_seen, suppress_seen;
  logic req_dma = 1'b0, phys_valid;
  sat_mode_t mode;
  int failures = 0, cmp_count = 0, n;
  sat_row_t rows [10] = '{
    '{7'h05, 16'h2311, 8'hFF, 8'h00, 0, 0, SAT_ST_OPFETCH, 16'h1528, 24'h232628, 0},
    '{7'h06, 16'h1000, 8'h20, 8'h00, 0, 0, SAT_ST_DATA, 16'h20FF, 24'h1020FF, 0},
    '{7'h06, 16'h1000, 8'h20, 8'h00, 0, 0, SAT_ST_DATA, 16'h2100, 24'h0, 1},
    '{7'h07, 16'h0400, 8'hFF, 8'h02, 0, 0, SAT_ST_DATA, 16'h0010, 24'h0, 1},
    '{7'h07, 16'h0400, 8'hFF, 8'h02, 1, 0, SAT_ST_DATA, 16'h0010, 24'h040010, 0},
    '{7'h08, 16'h0500, 8'hFF, 8'h01, 0, 1, SAT_ST_DATA, 16'h0020, 24'h0, 1},
    '{7'h08, 16'h0500, 8'hFF, 8'h01, 0, 0, SAT_ST_STACK, 16'h0020, 24'h050020, 0},
    '{7'h09, 16'h0600, 8'hFF, 8'h08, 0, 0, SAT_ST_DATA, 16'h0000, 24'h0, 1},
    '{7'h0A, 16'h0700, 8'hFF, 8'h04, 0, 0, SAT_ST_OPFETCH, 16'h0000, 24'h0, 1},
    '{7'h0B, 16'h0300, 8'hFF, 8'h00, 0, 1, SAT_ST_STACK, 16'h0042, 24'h030042, 0}};
  sat_if sat_if_i ();
  sat_cpu_end sat_cpu_end_i (.mclk(mclk), .sys_rst(sys_rst), .bus(sat_if_i.cpu), .req_valid(req_valid),
    .req_first(req_first), .req_last(req_last), .req_dma(req_dma), .req_status(req_status), .req_system(req_system),
    .req_write(req_write), .req_seg(req_seg), .req_ofs(req_ofs), .phys_addr(phys_addr), .phys_valid(phys_valid),
    .trap_seen(trap_seen), .suppress_seen(suppress_seen), .cmd_data(cmd_data));
  sat_mmu sat_mmu_i (.mclk(mclk), .sys_rst(sys_rst), .bus(sat_if_i.dev), .mode(mode), .violation());
  sat_chk sat_chk_i (.mclk(mclk), .sys_rst(sys_rst), .first_cycle(sat_if_i.first_cycle),
    .cycle_valid(sat_if_i.cycle_valid), .dma_cycle(sat_if_i.dma_cycle), .instr_end(sat_if_i.instr_end),
    .status(sat_if_i.status), .trap_ack(sat_if_i.trap_ack), .addr_oe_n(sat_if_i.addr_oe_n),
    .seg_trap(sat_if_i.seg_trap), .suppress(sat_if_i.suppress));
  initial
  begin
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [23:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic drv(input logic f, l, sy, wr, input sat_status_t st, input logic [6:0] seg, input logic [15:0] ofs);
    @(negedge mclk);
    req_valid = 1'b1;
    req_first = f;
    req_last = l;
    req_system = sy;
    req_write = wr;
    req_status = st;
    req_seg = seg;
    req_ofs = ofs;
  endtask
  task automatic wt(input int k);
    repeat (k)
    begin
      @(negedge mclk);
      req_valid = 1'b0;
      req_first = 1'b0;
      req_last = 1'b0;
    end
  endtask
  // Register access is a two-cycle special I/O instruction: field, then data
  task automatic cmd(input logic [6:0] seg, input logic wr, input logic [1:0] fld, input logic [15:0] ad);
    drv(1, 0, 1, 0, SAT_ST_SPECIAL_IO, seg, {14'h0000, fld});
    drv(0, 1, 1, wr, SAT_ST_SPECIAL_IO, seg, ad);
    wt(3);
  endtask
  // Trap stays up until the processor end acknowledges
  task automatic trap_gone();
    for (n = 0; n < 20 && trap_seen !== 1'b0; n++) @(negedge mclk);
    chk({23'h0, trap_seen}, 24'h0);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    wt(20);
    sys_rst = 1'b0;
    chk({23'h0, sat_if_i.addr_oe_n}, 24'h1);
    foreach (rows[i])
    begin
      cmd(rows[i].seg, 1, SAT_CMD_BASE, rows[i].base);
      cmd(rows[i].seg, 1, SAT_CMD_LIMIT, {rows[i].lim, 8'h00});
      cmd(rows[i].seg, 1, SAT_CMD_ATTR, {rows[i].attr, 8'h00});
      drv(1, 1, rows[i].sy, rows[i].wr, rows[i].st, rows[i].seg, rows[i].ofs);
      wt(2);
      chk({23'h0, trap_seen}, {23'h0, rows[i].trap});
      chk({23'h0, suppress_seen}, {23'h0, rows[i].trap});
      chk({23'h0, phys_valid}, 24'h1);
      if (!rows[i].trap) chk(phys_addr, rows[i].phys);
      trap_gone();
    end
    cmd(7'h0B, 0, SAT_CMD_ATTR, 16'h0000);
    chk({22'h0, cmd_data[SAT_ATTR_REF:SAT_ATTR_CHG]}, 24'h3);
    cmd(7'h08, 0, SAT_CMD_ATTR, 16'h0000);
    chk({22'h0, cmd_data[SAT_ATTR_REF:SAT_ATTR_CHG]}, 24'h2);
    // DMA may reach a segment closed to the processor
    req_dma = 1'b1;
    drv(1, 1, 0, 0, SAT_ST_DATA, 7'h0A, 16'h0100);
    wt(2);
    req_dma = 1'b0;
    chk({23'h0, trap_seen}, 24'h0);
    chk(phys_addr, 24'h070100);
    drv(1, 1, 0, 0, SAT_ST_IO, 7'h05, 16'h1528);
    wt(2);
    chk({23'h0, sat_if_i.addr_oe_n}, 24'h1);
    chk({21'h0, mode}, {21'h0, SAT_MODE_QUIET});
    drv(1, 1, 0, 0, SAT_ST_REFRESH, 7'h05, 16'h1528);
    wt(2);
    chk({23'h0, sat_if_i.addr_oe_n}, 24'h1);
    drv(1, 0, 0, 0, SAT_ST_DATA, 7'h06, 16'h2100);
    drv(0, 0, 0, 0, SAT_ST_DATA, 7'h05, 16'h0000);
    // An intervening DMA cycle is not suppressed
    req_dma = 1'b1;
    drv(0, 1, 0, 0, SAT_ST_DATA, 7'h05, 16'h0000);
    req_dma = 1'b0;
    chk({23'h0, sat_if_i.suppress}, 24'h0);
    wt(1);
    chk({23'h0, sat_if_i.suppress}, 24'h1);
    wt(4);
    chk({23'h0, sat_if_i.suppress}, 24'h0);
    trap_gone();
    // Reset in mid-run drops a pending trap and restores the table
    drv(1, 1, 0, 0, SAT_ST_DATA, 7'h06, 16'h2100);
    wt(1);
    sys_rst = 1'b1;
    wt(2);
    sys_rst = 1'b0;
    chk({22'h0, sat_if_i.seg_trap, sat_if_i.suppress}, 24'h0);
    drv(1, 1, 0, 0, SAT_ST_DATA, 7'h05, 16'h1528);
    wt(2);
    chk(phys_addr, 24'h001528);
    tally_and_finish();
  end
endmodule
